/* src/acf_pkg.sv */
// Shared constants, types and rate planning for the converter configuration core
package acf_pkg;

   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned MOD_DIV = 8;
   localparam int unsigned MOD_HZ = CLK_HZ / MOD_DIV;
   localparam logic [2:0] MOD_DIV_LAST = 3'(MOD_DIV - 1);
   // Rates are held in tenths of a sample per second
   localparam int unsigned STAGE2_IN_X10 = 144000;
   localparam int unsigned FIR_MAX_X10 = 200;
   localparam int unsigned CSRC_MAX_UA = 3000;
   localparam int N_ORDER = 5;
   localparam int N_PIN = 4;
   localparam int ACC_W = 90;
   localparam int OUT_W = 32;
   localparam int S1_LSB = 24;
   localparam int FIFO_DEPTH = 8;
   localparam logic [2:0] BYPASS_DISCARD = 3'h4;

   localparam logic [1:0] SEL_INT = 2'h0;
   localparam logic [1:0] SEL_SUP = 2'h1;
   localparam logic [1:0] SEL_EXT0 = 2'h2;
   localparam logic [1:0] SEL_EXT1 = 2'h3;

   localparam logic [2:0] FILT_SINC1 = 3'h0;
   localparam logic [2:0] FILT_SINC4 = 3'h3;
   localparam logic [2:0] FILT_FIR = 3'h5;
   localparam logic [4:0] RATE_RST = 5'h04;

   typedef enum logic [1:0] {ST_FLUSH = 2'b01, ST_RUN = 2'b10} acf_state_t;

   typedef struct packed {
      logic [3:0] pin;
      logic [3:0] level;
   } acf_csrc_t;

   typedef struct packed {
      logic [3:0] attach;
      logic [3:0] dir;
      logic [3:0] value;
      logic acx_en;
   } acf_pins_t;

   typedef struct packed {
      logic vsrc_en;
      logic [1:0] pos_sel;
      logic [1:0] neg_sel;
      acf_csrc_t cs1;
      acf_csrc_t cs2;
      acf_pins_t pins;
      logic [4:0] rate;
      logic [2:0] filt;
   } acf_cfg_t;

   typedef struct packed {
      logic int_on;
      logic [1:0] pos;
      logic [1:0] neg;
      logic int_selected;
   } acf_vsrc_t;

   typedef struct packed {
      logic bypass;
      logic fir;
      logic [2:0] order;
      logic [15:0] r1;
      logic [15:0] r2;
   } acf_plan_t;

   localparam acf_cfg_t CFG_RST = '{vsrc_en: 1'b0, pos_sel: SEL_SUP, neg_sel: SEL_SUP, cs1: '0, cs2: '0,
      pins: '{attach: 4'h0, dir: 4'hF, value: 4'h0, acx_en: 1'b0}, rate: RATE_RST, filt: FILT_SINC4};

   function automatic int unsigned rate_x10(input logic [4:0] code);
      unique case (code)
         5'h00: rate_x10 = 25;
         5'h01: rate_x10 = 50;
         5'h02: rate_x10 = 100;
         5'h03: rate_x10 = 166;
         5'h05: rate_x10 = 500;
         5'h06: rate_x10 = 600;
         5'h07: rate_x10 = 1000;
         5'h08: rate_x10 = 4000;
         5'h09: rate_x10 = 12000;
         5'h0A: rate_x10 = 24000;
         5'h0B: rate_x10 = 48000;
         5'h0C: rate_x10 = 72000;
         5'h0D: rate_x10 = 144000;
         5'h0E: rate_x10 = 192000;
         5'h0F: rate_x10 = 256000;
         5'h10: rate_x10 = 400000;
         default: rate_x10 = 200;
      endcase
   endfunction

   function automatic acf_plan_t plan_of(input logic [4:0] rate, input logic [2:0] filt);
      int unsigned x10;
      acf_plan_t p;
      x10 = rate_x10(rate);
      p.bypass = (x10 >= STAGE2_IN_X10);
      p.r1 = 16'((MOD_HZ * 10) / (p.bypass ? x10 : STAGE2_IN_X10));
      p.r2 = p.bypass ? 16'h0001 : 16'(STAGE2_IN_X10 / x10);
      p.fir = (filt == FILT_FIR) && (x10 <= FIR_MAX_X10);
      // High rates always run the fixed fifth-order first stage
      if (p.bypass) p.order = 3'h5;
      else if (p.fir || filt > 3'h4) p.order = 3'h1;
      else p.order = filt + 3'h1;
      return p;
   endfunction

   localparam acf_plan_t PLAN_RST = plan_of(RATE_RST, FILT_SINC4);

endpackage

/* src/acf_sync.sv */
// Two-flop level synchronizer, one per bit
`timescale 1ns/1ps
module acf_sync #(parameter int N = 4) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [N-1:0] d,
   output logic [N-1:0] q
);
   logic [N-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // acf_sync

/* src/acf_fifo.sv */
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module acf_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 8) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r, rd_r;
   logic [AW:0] cnt_r;
   logic push, pop;

   assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_r];

   always_ff @(posedge clk) begin
      if (push) mem[wr_r] <= in_data;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
         if (pop) rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
         if (push && !pop) cnt_r <= cnt_r + 1'b1;
         else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // acf_fifo

/* src/acf_core.sv */
// Reference, excitation, pin and decimation control core of the converter
// What this block does
// RQ1: Internal reference stays off after reset, powered only while its enable bit is set.
// RQ2: Both select fields at 00b route the internal reference to the converter.
// RQ3: Code 10b picks external pair on inputs 0/1; 11b picks inputs 2/3 on the larger variant.
// RQ4: Code 01b picks the analog supply difference; this is the reset selection.
// RQ5: Low-reference alarm sets whenever the muxed reference is below 0.4 V.
// RQ6: Low-reference alarm is read-only and clears at a later conversion once the cause left.
// RQ7: Software enables the internal reference before using excitation currents and lets it settle.
// RQ8: Each excitation current has its own pin select and magnitude field up to 3000 uA.
// RQ9: Larger variant has four general pins shared with analog inputs two to five.
// RQ10: A general pin reaches its package pin only while its attach bit is 1.
// RQ11: Direction bit 0 makes a pin an output, 1 makes it an input.
// RQ12: Four pin value bits drive outputs on write and return input levels on read.
// RQ13: Output pins read back the last written value, not the sensed level.
// RQ14: AC-excitation drive overrides programmed pin values while that mode is active.
// RQ15: Modulator samples at clock over 8 and feeds a ones-density stream to the filter.
// RQ16: Sinc mode covers 2.5 to 40000 samples per second with orders 1 to 5.
// RQ17: FIR mode exists only at 2.5 to 20 samples per second and settles in one conversion.
// RQ18: At 40000, 25600, 19200 and 14400 the fifth-order first stage output bypasses stage two.
// RQ19: Below that, stage two takes 14400 data and decimates to 7200 down to 2.5 at chosen order.
// RQ20: A five-bit rate field in the first mode register selects the output rate.
// RQ21: A three-bit filter mode field in the first mode register selects type and order.
// RQ22: Software waits for the level-shift voltage to settle before starting conversions.
// RQ23: Positive and negative reference selects are independent two-bit fields.
// RQ24: Input pins pass through a two-flop synchronizer before being read back.
// RQ25: The alarm is re-evaluated at each conversion start and held through that conversion.
`timescale 1ns/1ps
module acf_core #(parameter bit LARGE_VARIANT = 1'b1) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CFG_WR,
   input wire acf_pkg::acf_cfg_t CFG_IN,
   output acf_pkg::acf_cfg_t CFG_RD,
   output acf_pkg::acf_vsrc_t VSRC,
   output acf_pkg::acf_csrc_t CSRC1,
   output acf_pkg::acf_csrc_t CSRC2,
   input wire logic REF_LOW_CMP,
   output logic LOW_VSRC_ALARM,
   input wire logic [3:0] GPIO_I,
   output logic [3:0] GPIO_O,
   output logic [3:0] GPIO_OE,
   output logic MOD_SAMPLE,
   input wire logic MOD_BIT,
   output logic CONV_START,
   output logic DATA_VALID,
   input wire logic DATA_READY,
   output logic [31:0] DATA,
   output logic DATA_OVERRUN
);
   localparam int ORD = acf_pkg::N_ORDER;
   localparam int W = acf_pkg::ACC_W;
   localparam int OW = acf_pkg::OUT_W;
   localparam int NP = acf_pkg::N_PIN;

   acf_pkg::acf_cfg_t cfg_r, rd;
   acf_pkg::acf_plan_t plan_r;
   acf_pkg::acf_state_t state_r;
   logic restart_r, mod_stb, mod_smp_r, s1_hit, s2_hit, s1_vld_r, s2_vld_r;
   logic fin_stb, push, fifo_rdy, conv_r, alarm_r, overrun_r, phase_r;
   logic [2:0] div_r, oi, discard, settle_r;
   logic [15:0] k1_r, k2_r;
   logic [OW-1:0] s1_out_r, s2_out_r, fin_data;
   logic [W-1:0] i1 [ORD], d1 [ORD], c1 [ORD], f1 [ORD], e1 [ORD];
   logic [W-1:0] i2 [ORD], d2 [ORD], c2 [ORD], f2 [ORD], e2 [ORD];
   logic [NP-1:0] pin_in, attach_m, acx_drv, gpio_o_r, gpio_oe_r, rd_val_r;

   // Configuration store; a rate or filter change restarts the decimator
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_r <= acf_pkg::CFG_RST; // see RQ1 see RQ4
         restart_r <= 1'b0;
      end else begin
         if (CFG_WR) cfg_r <= CFG_IN; // see RQ20 see RQ21 see RQ23
         restart_r <= CFG_WR && ({CFG_IN.rate, CFG_IN.filt} != {cfg_r.rate, cfg_r.filt});
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) plan_r <= acf_pkg::PLAN_RST;
      else plan_r <= acf_pkg::plan_of(cfg_r.rate, cfg_r.filt); // see RQ16 see RQ17
   end

   // Reference routing is passed straight from the stored selects
   assign VSRC.int_on = cfg_r.vsrc_en; // see RQ1
   assign VSRC.pos = cfg_r.pos_sel; // see RQ3 see RQ4 see RQ23
   assign VSRC.neg = cfg_r.neg_sel; // see RQ23
   assign VSRC.int_selected = (cfg_r.pos_sel == acf_pkg::SEL_INT) && (cfg_r.neg_sel == acf_pkg::SEL_INT); // see RQ2
   assign CSRC1 = cfg_r.cs1; // see RQ8
   assign CSRC2 = cfg_r.cs2; // see RQ8

   // Modulator sample strobe at the clock over eight
   assign mod_stb = (div_r == acf_pkg::MOD_DIV_LAST); // see RQ15
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         div_r <= 3'h0;
         mod_smp_r <= 1'b0;
      end else begin
         div_r <= mod_stb ? 3'h0 : div_r + 3'h1;
         mod_smp_r <= mod_stb;
      end
   end
   assign MOD_SAMPLE = mod_smp_r;

   // Decimation counters for both stages
   assign s1_hit = mod_stb && (k1_r == plan_r.r1 - 16'h0001);
   assign s2_hit = s1_vld_r && (k2_r == plan_r.r2 - 16'h0001); // see RQ19
   assign oi = plan_r.order - 3'h1;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         k1_r <= 16'h0000;
         k2_r <= 16'h0000;
         s1_vld_r <= 1'b0;
         s2_vld_r <= 1'b0;
         s1_out_r <= '0;
         s2_out_r <= '0;
      end else if (restart_r) begin
         k1_r <= 16'h0000;
         k2_r <= 16'h0000;
         s1_vld_r <= 1'b0;
         s2_vld_r <= 1'b0;
      end else begin
         if (mod_stb) k1_r <= s1_hit ? 16'h0000 : k1_r + 16'h0001;
         if (s1_vld_r) k2_r <= s2_hit ? 16'h0000 : k2_r + 16'h0001;
         s1_vld_r <= s1_hit;
         s2_vld_r <= s2_hit;
         if (s1_hit) s1_out_r <= c1[ORD-1][acf_pkg::S1_LSB +: OW]; // see RQ18
         if (s2_hit) s2_out_r <= c2[oi][OW-1:0]; // see RQ19
      end
   end

   // Integrator and comb chains; wrap-around arithmetic keeps the low bits exact
   for (genvar g = 0; g < ORD; g++) begin : g_cic
      if (g == 0) begin : g_head
         assign f1[g] = W'(MOD_BIT); // see RQ15
         assign e1[g] = i1[ORD-1];
         assign f2[g] = W'(s1_out_r);
         assign e2[g] = i2[oi];
      end else begin : g_tail
         assign f1[g] = i1[g-1];
         assign e1[g] = c1[g-1];
         assign f2[g] = i2[g-1];
         assign e2[g] = c2[g-1];
      end
      assign c1[g] = e1[g] - d1[g];
      assign c2[g] = e2[g] - d2[g];

      always_ff @(posedge CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            i1[g] <= '0;
            d1[g] <= '0;
         end else if (restart_r) begin
            i1[g] <= '0;
            d1[g] <= '0;
         end else begin
            if (mod_stb) i1[g] <= i1[g] + f1[g];
            if (s1_hit) d1[g] <= e1[g];
         end
      end

      always_ff @(posedge CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            i2[g] <= '0;
            d2[g] <= '0;
         end else if (restart_r) begin
            i2[g] <= '0;
            d2[g] <= '0;
         end else begin
            if (s1_vld_r) i2[g] <= i2[g] + f2[g];
            if (s2_hit) d2[g] <= e2[g]; // see RQ16
         end
      end
   end

   assign fin_stb = plan_r.bypass ? s1_vld_r : s2_vld_r; // see RQ18
   assign fin_data = plan_r.bypass ? s1_out_r : s2_out_r;

   // Unsettled results after a restart are dropped; FIR needs none dropped
   assign discard = plan_r.fir ? 3'h0 : (plan_r.bypass ? acf_pkg::BYPASS_DISCARD : oi); // see RQ17
   assign push = fin_stb && ((state_r == acf_pkg::ST_RUN) || (settle_r == discard));
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= acf_pkg::ST_FLUSH;
         settle_r <= 3'h0;
      end else if (restart_r) begin
         state_r <= acf_pkg::ST_FLUSH;
         settle_r <= 3'h0;
      end else begin
         unique case (state_r)
            acf_pkg::ST_FLUSH: begin
               if (fin_stb) begin
                  if (settle_r == discard) state_r <= acf_pkg::ST_RUN;
                  else settle_r <= settle_r + 3'h1;
               end
            end
            acf_pkg::ST_RUN: state_r <= acf_pkg::ST_RUN;
            default: state_r <= acf_pkg::ST_FLUSH;
         endcase
      end
   end

   // Modulator data cannot be held back, so a full FIFO drops the result and flags it
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) overrun_r <= 1'b0;
      else overrun_r <= (overrun_r && !restart_r) || (push && !fifo_rdy);
   end
   assign DATA_OVERRUN = overrun_r;

   acf_fifo #(.WIDTH(OW), .DEPTH(acf_pkg::FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .arst_n(ARST_N),
      .in_valid(push),
      .in_ready(fifo_rdy),
      .in_data(fin_data),
      .out_valid(DATA_VALID),
      .out_ready(DATA_READY),
      .out_data(DATA)
   );

   // Alarm reloads from the comparator at each conversion start and is sticky inside it
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         alarm_r <= 1'b0;
         conv_r <= 1'b0;
      end else begin
         alarm_r <= fin_stb ? REF_LOW_CMP : (alarm_r || REF_LOW_CMP); // see RQ5 see RQ6 see RQ25
         conv_r <= fin_stb;
      end
   end
   assign LOW_VSRC_ALARM = alarm_r;
   assign CONV_START = conv_r;

   // Excitation phase flips once per conversion
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) phase_r <= 1'b0;
      else if (!cfg_r.pins.acx_en) phase_r <= 1'b0;
      else if (fin_stb) phase_r <= !phase_r;
   end
   assign acx_drv = {!phase_r, phase_r, !phase_r, phase_r};

   acf_sync #(.N(NP)) u_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .d(GPIO_I),
      .q(pin_in)
   ); // see RQ24

   // The smaller variant has no general pins
   assign attach_m = LARGE_VARIANT ? cfg_r.pins.attach : 4'h0; // see RQ9
   for (genvar p = 0; p < NP; p++) begin : g_pin
      always_ff @(posedge CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            gpio_o_r[p] <= 1'b0;
            gpio_oe_r[p] <= 1'b0;
            rd_val_r[p] <= 1'b0;
         end else begin
            gpio_oe_r[p] <= attach_m[p] && (cfg_r.pins.acx_en || !cfg_r.pins.dir[p]); // see RQ10 see RQ11
            gpio_o_r[p] <= cfg_r.pins.acx_en ? acx_drv[p] : cfg_r.pins.value[p]; // see RQ12 see RQ14
            rd_val_r[p] <= cfg_r.pins.dir[p] ? pin_in[p] : cfg_r.pins.value[p]; // see RQ12 see RQ13
         end
      end
   end
   assign GPIO_O = gpio_o_r;
   assign GPIO_OE = gpio_oe_r;

   always_comb begin
      rd = cfg_r;
      rd.pins.value = rd_val_r;
      rd.pins.attach = attach_m;
   end
   assign CFG_RD = rd;

   a_int_vsrc_on: assert property (@(posedge CLK) disable iff (!ARST_N)
      $rose(VSRC.int_on) |-> $past(CFG_WR && CFG_IN.vsrc_en)) else $error("internal ref rose without write"); // see RQ1
   a_int_route: assert property (@(posedge CLK) disable iff (!ARST_N)
      VSRC.int_selected |-> (VSRC.pos == 2'h0 && VSRC.neg == 2'h0)) else $error("internal route wrong"); // see RQ2
   a_mod_rate: assert property (@(posedge CLK) disable iff (!ARST_N)
      MOD_SAMPLE |=> !MOD_SAMPLE [*7] ##1 MOD_SAMPLE) else $error("modulator strobe not every 8"); // see RQ15
   a_alarm_set: assert property (@(posedge CLK) disable iff (!ARST_N)
      REF_LOW_CMP |=> LOW_VSRC_ALARM) else $error("low ref alarm missed"); // see RQ5
   a_alarm_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
      (LOW_VSRC_ALARM && !fin_stb) |=> LOW_VSRC_ALARM) else $error("alarm dropped mid conversion"); // see RQ6
   a_alarm_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
      (fin_stb && !REF_LOW_CMP) |=> !LOW_VSRC_ALARM) else $error("alarm not cleared at start"); // see RQ25
   a_pin_readback: assert property (@(posedge CLK) disable iff (!ARST_N)
      (!cfg_r.pins.dir[0] && !CFG_WR) |=> ##1 CFG_RD.pins.value[0] == $past(cfg_r.pins.value[0], 2))
      else $error("output pin readback wrong"); // see RQ13
   a_pin_drive: assert property (@(posedge CLK) disable iff (!ARST_N)
      (attach_m[1] && !cfg_r.pins.dir[1] && !cfg_r.pins.acx_en)
      |=> GPIO_OE[1] && GPIO_O[1] == $past(cfg_r.pins.value[1])) else $error("pin not driven"); // see RQ11
   a_pin_detached: assert property (@(posedge CLK) disable iff (!ARST_N)
      !attach_m[2] |=> !GPIO_OE[2]) else $error("detached pin driven"); // see RQ10
   a_acx_override: assert property (@(posedge CLK) disable iff (!ARST_N)
      (cfg_r.pins.acx_en && attach_m[0]) |=> GPIO_OE[0] && GPIO_O[0] == $past(phase_r))
      else $error("excitation did not override pin"); // see RQ14
   a_bypass_out: assert property (@(posedge CLK) disable iff (!ARST_N)
      (plan_r.bypass && s1_vld_r) |-> fin_stb && fin_data == s1_out_r) else $error("bypass not taken"); // see RQ18
   a_stage2_feed: assert property (@(posedge CLK) disable iff (!ARST_N)
      (!plan_r.bypass && s2_hit) |-> s1_vld_r && plan_r.r1 == 16'(acf_pkg::MOD_HZ * 10 / acf_pkg::STAGE2_IN_X10))
      else $error("stage two fed at wrong rate"); // see RQ19
   a_sinc_order: assert property (@(posedge CLK) disable iff (!ARST_N)
      (!plan_r.bypass && $past(cfg_r.filt) < 3'h5) |-> plan_r.order == $past(cfg_r.filt) + 3'h1)
      else $error("sinc order not as programmed"); // see RQ16
   a_fir_single: assert property (@(posedge CLK) disable iff (!ARST_N)
      plan_r.fir |-> plan_r.order == 3'h1 && discard == 3'h0) else $error("FIR not single-cycle"); // see RQ17
endmodule // acf_core

/* tb/acf_core_bench.sv */
// Self-checking bench for the converter configuration core
`timescale 1ns/1ps
module acf_core_bench;
   // Bypass word for a stream of all ones: fifth-order gain of 625, bits 55:24
   localparam logic [31:0] ONES_WORD = 32'((64'd625 ** 5) >> 24);
   logic clk, arst_n, cfg_wr, ref_low_cmp, mod_bit, data_ready, ones;
   logic [3:0] gpio_i, gpio_o, gpio_oe;
   logic low_alarm, mod_sample, conv_start, data_valid, data_overrun;
   logic [31:0] data, last;
   logic [63:0] r;
   acf_pkg::acf_cfg_t cfg_in, cfg_rd, c;
   acf_pkg::acf_vsrc_t vsrc;
   acf_pkg::acf_csrc_t csrc1, csrc2;
   int failures, cmp_count, n, t0;
   int cyc = 0;

   acf_core u_acf_core (.CLK(clk), .ARST_N(arst_n), .CFG_WR(cfg_wr), .CFG_IN(cfg_in), .CFG_RD(cfg_rd),
      .VSRC(vsrc), .CSRC1(csrc1), .CSRC2(csrc2), .REF_LOW_CMP(ref_low_cmp), .LOW_VSRC_ALARM(low_alarm),
      .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .MOD_SAMPLE(mod_sample), .MOD_BIT(mod_bit),
      .CONV_START(conv_start), .DATA_VALID(data_valid), .DATA_READY(data_ready), .DATA(data),
      .DATA_OVERRUN(data_overrun));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // Random bits keep the decimator busy; all ones make its output predictable
   always @(negedge clk) mod_bit <= ones ? 1'b1 : 1'($urandom);

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic write_cfg(input acf_pkg::acf_cfg_t v, input logic [3:0] pins);
      @(negedge clk);
      cfg_in = v;
      gpio_i = pins;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask

   task automatic wait_hi(input bit ovr, input int bound);
      int k;
      k = 0;
      do begin
         tick();
         k++;
      end while ((ovr ? data_overrun : conv_start) !== 1'b1 && k < bound);
      if ((ovr ? data_overrun : conv_start) !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask

   // Input pins read their synchronized level, output pins the stored value
   function automatic acf_pkg::acf_cfg_t exp_rd(input acf_pkg::acf_cfg_t v, input logic [3:0] pins);
      acf_pkg::acf_cfg_t e;
      e = v;
      e.pins.value = (v.pins.dir & pins) | (~v.pins.dir & v.pins.value);
      return e;
   endfunction

   initial begin
      failures = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_in = '0;
      ref_low_cmp = 1'b0;
      data_ready = 1'b1;
      gpio_i = 4'h0;
      ones = 1'b0;
      void'($urandom(64));
      repeat (6) @(posedge clk);
      #1;
      check(vsrc, {1'b0, 2'h1, 2'h1, 1'b0});
      check(cfg_rd, acf_pkg::CFG_RST);
      check({gpio_oe, low_alarm}, 5'h00);
      @(negedge clk);
      arst_n = 1'b1;
      // Level shift is never switched on here, so no settling wait is owed
      // First sixteen writes walk every pair of select codes
      for (int i = 0; i < 24; i++) begin
         r = {$urandom, $urandom};
         c = r[$bits(c)-1:0];
         c.pins.acx_en = 1'b0;
         // Excitation currents only run while the internal reference is on
         if (i % 2 == 0) {c.cs1.level, c.cs2.level} = 8'h00;
         else c.vsrc_en = 1'b1;
         if (i < 16) {c.pos_sel, c.neg_sel} = 4'(i);
         write_cfg(c, 4'($urandom));
         tick();
         check(vsrc, {c.vsrc_en, c.pos_sel, c.neg_sel, c.pos_sel == 2'h0 && c.neg_sel == 2'h0});
         check({csrc1, csrc2}, {c.cs1, c.cs2});
         tick();
         check({gpio_oe, gpio_o}, {c.pins.attach & ~c.pins.dir, c.pins.value});
         tick();
         check(cfg_rd, exp_rd(c, gpio_i));
      end
      n = 0;
      repeat (80) begin
         tick();
         n += (mod_sample === 1'b1);
      end
      check(n, 10);
      @(negedge clk);
      data_ready = 1'b0;
      ones = 1'b1;
      c = '0;
      c.pins.dir = 4'hF;
      c.rate = 5'h10;
      c.filt = 3'h3;
      write_cfg(c, 4'h0);
      wait_hi(1'b0, 6000);
      t0 = cyc;
      wait_hi(1'b0, 6000);
      check(cyc - t0, 8 * 625);
      @(negedge clk);
      ref_low_cmp = 1'b1;
      @(negedge clk);
      ref_low_cmp = 1'b0;
      repeat (100) tick();
      check(low_alarm, 1'b1);
      wait_hi(1'b0, 6000);
      check(low_alarm, 1'b0);
      // Far side stalls until the buffer refuses a result
      wait_hi(1'b1, 80000);
      check(data_valid, 1'b1);
      @(negedge clk);
      data_ready = 1'b1;
      n = 0;
      while (data_valid === 1'b1 && n < 20) begin
         last = data;
         n++;
         @(negedge clk);
      end
      data_ready = 1'b0;
      check(n, acf_pkg::FIFO_DEPTH);
      check(last, ONES_WORD);
      check(data_overrun, 1'b1);
      wait_hi(1'b0, 6000);
      // Stored value differs from both drive phases, so a missing override shows
      c.pins = '{attach: 4'hF, dir: 4'h0, value: 4'h3, acx_en: 1'b1};
      write_cfg(c, 4'h0);
      tick();
      tick();
      check({gpio_oe, gpio_o}, 8'hFA);
      wait_hi(1'b0, 6000);
      tick();
      check(gpio_o, 4'h5);
      wrap_up();
   end
endmodule // acf_core_bench
